// >>> spp_password_check.sv
// Password gate for operation commands arriving over the serial link.
// Assumes flash read data follows flash_rd.addr in the same cycle, and that
// link bytes and commands are already decoded on clk.
//
// Notes on behaviour
// - With a password set, operation commands wait for authentication.
// - On-chip debug start is allowed only after authentication succeeded or in parallel programming mode.
// - Parallel programming mode applies no password restriction.
// - Password bytes must lie in flash 0x8000 to 0xFEFF.
// - Length pointer out of window, or its byte below 0x07, is an error.
// - Non-blank: compare pointer beyond 0xFEFF minus N is an error.
// - String of N bytes (8..255) compared with flash; mismatch is error.
// - Three or more identical consecutive string bytes is an error.
// - Error: silent, ignore link for good until pin reset.
// - Non-blank if any byte 0xFFE0..0xFFFF differs from 0xFF.
// - Blank part skips string compare but still checks both pointers.
// - Erase, write, read, loader, security commands demand pointers, string.
// - Whole-chip erase leaves all 0xFF, so the part becomes blank.
// - Blank write/loader goes to hex reception, discarding bytes until 0x3A.
// - Blank or non-blank state is reported for the status reply.
`timescale 1ns/100ps
`include "spp_params.svh"
module spp_password_check (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic parallel_mode_pin,
  input wire spp_pkg::spp_link_type link_in,
  input wire spp_pkg::spp_cmd_type cmd_in,
  input wire logic chip_erase_done,
  input wire logic debug_start_req,
  input wire logic [7:0] flash_rd_data,
  output spp_pkg::spp_flash_rd_type flash_rd,
  output logic cmd_go,
  output logic auth_ok,
  output logic lockup,
  output logic blank_part,
  output logic hex_start,
  output logic debug_go
);
  import spp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input and working state
  logic parallel_mode;
  spp_state_type state_reg;
  logic [23:0] ptr_reg;
  logic [23:0] len_ptr_reg;
  logic [15:0] cmp_base_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] len_reg;
  logic [7:0] idx_reg;
  logic [7:0] prev_reg;
  logic [7:0] rx_byte_reg;
  logic [1:0] run_reg;
  logic [4:0] scan_cnt_reg;
  logic scan_clean_reg;
  logic [7:0] cmd_reg;

  logic rx;
  logic needs_ptr;
  logic hex_cmd;
  logic [23:0] ptr_next;
  logic [23:0] cmp_hi;
  logic len_ptr_ok;
  logic cmp_ptr_ok;
  logic [1:0] run_next;

  spp_sync3 u_mode_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(parallel_mode_pin),
    .level_out(parallel_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign rx = link_in.valid;
  assign ptr_next = {ptr_reg[15:0], link_in.data};

  always_comb begin
    unique case (cmd_in.code)
      `SPP_CMD_ERASE, `SPP_CMD_WRITE, `SPP_CMD_READ,
      `SPP_CMD_LOADER, `SPP_CMD_SECURE: needs_ptr = 1'b1;
      default: needs_ptr = 1'b0;
    endcase
  end

  assign hex_cmd = (cmd_reg == `SPP_CMD_WRITE) ||
                   (cmd_reg == `SPP_CMD_LOADER);

  // Window checks use the fully assembled pointer
  assign len_ptr_ok = (len_ptr_reg >= `SPP_WIN_LO) &&
                      (len_ptr_reg <= `SPP_WIN_HI);
  assign cmp_hi = `SPP_WIN_HI - {16'h0000, len_reg};
  assign cmp_ptr_ok = (ptr_reg >= `SPP_WIN_LO) &&
                      (ptr_reg <= (blank_part ? `SPP_WIN_HI : cmp_hi));

  // Run length of identical bytes, including the one now received
  assign run_next = ((idx_reg != 8'h00) && (link_in.data == prev_reg)) ?
                    run_reg + 2'h1 : 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= SPP_SCAN_REQ;
      byte_cnt_reg <= 2'h0;
      idx_reg <= 8'h00;
      scan_cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        SPP_SCAN_REQ: begin
          state_reg <= SPP_SCAN_CHK;
        end
        SPP_SCAN_CHK: begin
          if (scan_cnt_reg == `SPP_BLANK_LAST) begin
            state_reg <= SPP_WAIT_CMD;
          end else begin
            scan_cnt_reg <= scan_cnt_reg + 5'h01;
            state_reg <= SPP_SCAN_REQ;
          end
        end
        SPP_WAIT_CMD: begin
          byte_cnt_reg <= 2'h0;
          idx_reg <= 8'h00;
          if (chip_erase_done) begin
            scan_cnt_reg <= 5'h00; // Re-derive blank state
            state_reg <= SPP_SCAN_REQ;
          end else if (cmd_in.start && !parallel_mode) begin
            if (needs_ptr) begin
              state_reg <= SPP_LEN_PTR;
            end
          end
        end
        SPP_LEN_PTR: begin
          if (rx) begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            if (byte_cnt_reg == `SPP_PTR_LAST) begin
              state_reg <= SPP_LEN_RD;
            end
          end
        end
        SPP_LEN_RD: begin
          state_reg <= len_ptr_ok ? SPP_LEN_CHK : SPP_LOCK;
        end
        SPP_LEN_CHK: begin
          byte_cnt_reg <= 2'h0;
          if ((flash_rd_data < `SPP_LEN_MIN) ||
              (!blank_part && (flash_rd_data < `SPP_STR_MIN))) begin
            state_reg <= SPP_LOCK;
          end else begin
            state_reg <= SPP_CMP_PTR;
          end
        end
        SPP_CMP_PTR: begin
          if (rx) begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            if (byte_cnt_reg == `SPP_PTR_LAST) begin
              state_reg <= SPP_CMP_CHK;
            end
          end
        end
        SPP_CMP_CHK: begin
          if (!cmp_ptr_ok) begin
            state_reg <= SPP_LOCK;
          end else if (blank_part) begin
            // No string for a blank part
            state_reg <= hex_cmd ? SPP_HEX_WAIT : SPP_WAIT_CMD;
          end else begin
            state_reg <= SPP_STR_RX;
          end
        end
        SPP_STR_RX: begin
          if (rx) begin
            state_reg <= (run_next == `SPP_RUN_MAX) ?
                         SPP_LOCK : SPP_STR_CHK;
          end
        end
        SPP_STR_CHK: begin
          if (flash_rd_data != rx_byte_reg) begin
            state_reg <= SPP_LOCK;
          end else if (idx_reg == len_reg - 8'h01) begin
            state_reg <= hex_cmd ? SPP_HEX_WAIT : SPP_WAIT_CMD;
          end else begin
            idx_reg <= idx_reg + 8'h01;
            state_reg <= SPP_STR_RX;
          end
        end
        SPP_HEX_WAIT: begin
          if (rx && (link_in.data == `SPP_HEX_MARK)) begin
            state_reg <= SPP_WAIT_CMD; // Other bytes dropped
          end
        end
        SPP_LOCK: begin
          state_reg <= SPP_LOCK; // Only reset leaves
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and string capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_reg <= 24'h00_0000;
      len_ptr_reg <= 24'h00_0000;
      cmp_base_reg <= 16'h0000;
      len_reg <= 8'h00;
      prev_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      run_reg <= 2'h0;
      cmd_reg <= 8'h00;
    end else begin
      if ((state_reg == SPP_WAIT_CMD) && cmd_in.start) begin
        cmd_reg <= cmd_in.code;
      end
      if ((state_reg == SPP_LEN_PTR || state_reg == SPP_CMP_PTR) && rx) begin
        ptr_reg <= ptr_next; // MSB first
      end
      if ((state_reg == SPP_LEN_PTR) && rx &&
          (byte_cnt_reg == `SPP_PTR_LAST)) begin
        len_ptr_reg <= ptr_next;
      end
      if (state_reg == SPP_LEN_CHK) begin
        len_reg <= flash_rd_data;
      end
      if (state_reg == SPP_CMP_CHK) begin
        cmp_base_reg <= ptr_reg[15:0];
      end
      if ((state_reg == SPP_STR_RX) && rx) begin
        rx_byte_reg <= link_in.data;
        prev_reg <= link_in.data;
        run_reg <= run_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash read port, registered one cycle ahead of the check states
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flash_rd <= '0;
    end else begin
      flash_rd.en <= 1'b0;
      unique case (state_reg)
        SPP_WAIT_CMD: begin
          if (chip_erase_done) begin
            flash_rd.en <= 1'b1;
            flash_rd.addr <= `SPP_BLANK_LO;
          end
        end
        SPP_SCAN_CHK: begin
          flash_rd.en <= 1'b1;
          flash_rd.addr <= `SPP_BLANK_LO + {11'h000, scan_cnt_reg + 5'h01};
        end
        SPP_LEN_RD: begin
          flash_rd.en <= len_ptr_ok; // Never read outside the window
          flash_rd.addr <= len_ptr_reg[15:0];
        end
        SPP_STR_RX: begin
          flash_rd.en <= rx;
          flash_rd.addr <= cmp_base_reg + {8'h00, idx_reg};
        end
        default: begin
          flash_rd.en <= 1'b0;
        end
      endcase
      if (state_reg == SPP_SCAN_REQ) begin
        flash_rd.en <= 1'b1;
        flash_rd.addr <= `SPP_BLANK_LO + {11'h000, scan_cnt_reg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blank detection over the top 32 bytes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scan_clean_reg <= 1'b1;
      blank_part <= 1'b0;
    end else if (state_reg == SPP_SCAN_CHK) begin
      if (scan_cnt_reg == `SPP_BLANK_LAST) begin
        blank_part <= scan_clean_reg &&
                      (flash_rd_data == `SPP_ERASED);
        scan_clean_reg <= 1'b1;
      end else if (flash_rd_data != `SPP_ERASED) begin
        scan_clean_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant, authentication and status outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_go <= 1'b0;
      auth_ok <= 1'b0;
      lockup <= 1'b0;
      hex_start <= 1'b0;
      debug_go <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      hex_start <= 1'b0;
      debug_go <= 1'b0;
      lockup <= (state_reg == SPP_LOCK);
      if (chip_erase_done && (state_reg == SPP_WAIT_CMD)) begin
        auth_ok <= 1'b0; // Re-authenticate against the new contents
      end
      unique case (state_reg)
        SPP_WAIT_CMD: begin
          if (cmd_in.start && !chip_erase_done) begin
            if (parallel_mode) begin
              cmd_go <= 1'b1;
            end else if (!needs_ptr) begin
              cmd_go <= blank_part || auth_ok;
            end
          end
          debug_go <= debug_start_req && (auth_ok || parallel_mode);
        end
        SPP_CMP_CHK: begin
          if (cmp_ptr_ok && blank_part) begin
            auth_ok <= 1'b1;
            cmd_go <= !hex_cmd;
          end
        end
        SPP_STR_CHK: begin
          if ((flash_rd_data == rx_byte_reg) &&
              (idx_reg == len_reg - 8'h01)) begin
            auth_ok <= 1'b1;
            cmd_go <= !hex_cmd;
          end
        end
        SPP_HEX_WAIT: begin
          if (rx && (link_in.data == `SPP_HEX_MARK)) begin
            hex_start <= 1'b1;
            cmd_go <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// >>> spp_params.svh
// Constants for the serial password checker: address windows, byte codes.
// Assumes flash addresses are 16 bits and pointers arrive as three bytes.
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Address windows
`define SPP_WIN_LO 24'h00_8000
`define SPP_WIN_HI 24'h00_FEFF
`define SPP_BLANK_LO 16'hFFE0
`define SPP_BLANK_LAST 5'h1F

////////////////////////////////////////////////////////////////////////////
// Byte values and counts
`define SPP_ERASED 8'hFF
`define SPP_LEN_MIN 8'h07
`define SPP_STR_MIN 8'h08
`define SPP_RUN_MAX 2'h3
`define SPP_HEX_MARK 8'h3A
`define SPP_PTR_LAST 2'h2

////////////////////////////////////////////////////////////////////////////
// Operation commands that need the pointer fields
`define SPP_CMD_ERASE 8'hF0
`define SPP_CMD_WRITE 8'h30
`define SPP_CMD_READ 8'h40
`define SPP_CMD_LOADER 8'h60
`define SPP_CMD_SECURE 8'hFA

`endif

// >>> spp_pkg.sv
// Types shared by the serial password checker and its test bench.
// Assumes the link byte stream and command decode run on the same clock.
package spp_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spp_link_type;

  typedef struct packed {
    logic start;
    logic [7:0] code;
  } spp_cmd_type;

  typedef struct packed {
    logic en;
    logic [15:0] addr;
  } spp_flash_rd_type;

  typedef enum logic [3:0] {
    SPP_SCAN_REQ,
    SPP_SCAN_CHK,
    SPP_WAIT_CMD,
    SPP_LEN_PTR,
    SPP_LEN_RD,
    SPP_LEN_CHK,
    SPP_CMP_PTR,
    SPP_CMP_CHK,
    SPP_STR_RX,
    SPP_STR_CHK,
    SPP_HEX_WAIT,
    SPP_LOCK
  } spp_state_type;

endpackage

// >>> spp_sync3.sv
// Three-stage synchroniser for a level from a pin.
// Assumes the input is asynchronous to clk; output is a flop.
`timescale 1ns/100ps
module spp_sync3 (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only a level seen on two later stages counts, so glitches are dropped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end

endmodule

// >>> spp_password_check_monitor.sv
// Checker for the serial password gate, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module spp_password_check_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic parallel_mode_pin,
  input wire spp_pkg::spp_link_type link_in,
  input wire spp_pkg::spp_cmd_type cmd_in,
  input wire logic chip_erase_done,
  input wire logic debug_start_req,
  input wire logic [7:0] flash_rd_data,
  input wire spp_pkg::spp_flash_rd_type flash_rd,
  input wire logic cmd_go,
  input wire logic auth_ok,
  input wire logic lockup,
  input wire logic blank_part,
  input wire logic hex_start,
  input wire logic debug_go
);
  import spp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////
  chk_lock_sticky: assert property (lockup |=> lockup)
    else $error("lockup dropped without reset");
  chk_lock_silent: assert property (lockup |-> !cmd_go && !debug_go)
    else $error("output pulse while locked");
  chk_debug_gate: assert property (debug_go |->
    $past(debug_start_req) && ($past(auth_ok) ||
    $past(parallel_mode_pin, 5)))
    else $error("debug granted without request or auth");
  chk_hex_go: assert property (hex_start |-> cmd_go)
    else $error("hex start without grant");
  chk_hex_mark: assert property (hex_start |-> $past(link_in.valid) &&
    $past(link_in.data) == 8'h3A)
    else $error("hex start without start mark");
  chk_go_auth: assert property (cmd_go |-> auth_ok || blank_part ||
    $past(parallel_mode_pin, 5))
    else $error("grant on locked part");
  chk_erase_clear: assert property (chip_erase_done && !lockup
    && !flash_rd.en |=> !auth_ok)
    else $error("auth kept after chip erase");
  chk_rd_window: assert property (flash_rd.en |->
    flash_rd.addr >= 16'h8000)
    else $error("flash read below window");
  // Main scenarios reached
  cover property ($rose(lockup));
  cover property (hex_start);
  cover property (debug_go);
endmodule
bind spp_password_check spp_password_check_monitor u_mon (.clk(clk),
  .reset_n(reset_n), .parallel_mode_pin(parallel_mode_pin),
  .link_in(link_in), .cmd_in(cmd_in), .chip_erase_done(chip_erase_done),
  .debug_start_req(debug_start_req), .flash_rd_data(flash_rd_data),
  .flash_rd(flash_rd), .cmd_go(cmd_go), .auth_ok(auth_ok),
  .lockup(lockup), .blank_part(blank_part), .hex_start(hex_start),
  .debug_go(debug_go));

// >>> spp_prog_ctrl.sv
// Programming controller model: commands and link bytes.
// Assumes the bench calls its tasks; drives just after rising edges.
`timescale 1ns/100ps
module spp_prog_ctrl (
  input wire logic clk,
  output spp_pkg::spp_link_type link_in,
  output spp_pkg::spp_cmd_type cmd_in
);
  import spp_pkg::*;
  initial begin
    link_in = '0;
    cmd_in = '0;
  end
////////////////////////////////////////////////////////////////////////////
  // Released data inverted, so a stale byte never reads as valid
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    link_in <= '{valid: 1'b1, data: b};
    @(posedge clk);
    link_in <= '{valid: 1'b0, data: ~b};
    repeat (2) @(posedge clk); // Room for range check and compare
  endtask
  task automatic ptr(input logic [23:0] p);
    send(p[23:16]);
    send(p[15:8]);
    send(p[7:0]);
  endtask
  task automatic start(input logic [7:0] c);
    @(posedge clk);
    cmd_in <= '{start: 1'b1, code: c};
    @(posedge clk);
    cmd_in <= '{start: 1'b0, code: ~c};
  endtask
endmodule

// >>> test_spp_password_check.sv
// Self-checking bench for the serial password gate.
// Assumes a combinational flash image held here and the controller model.
`timescale 1ns/100ps
module test_spp_password_check;
  import spp_pkg::*;
  typedef struct {
    logic [23:0] lp;
    logic [23:0] cp;
    int bad;
    logic [7:0] code;
    logic lock;
  } spp_row_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic par_pin = 1'b0;
  logic erase_done = 1'b0;
  logic dbg_req = 1'b0;
  spp_link_type link_in;
  spp_cmd_type cmd_in;
  spp_flash_rd_type flash_rd;
  logic cmd_go, auth_ok, lockup, blank_part, hex_start, debug_go;
  logic go_seen, hex_seen, dbg_seen;
  logic [7:0] mem [0:65535];
  int fails = 0;
  int checks_done = 0;
  spp_row_type rows [13] = '{
    '{24'h00_8000, 24'h00_9000, -1, 8'h40, 1'b0},
    '{24'h00_8000, 24'h00_9100, -1, 8'hF0, 1'b0},
    '{24'h00_8000, 24'h00_9200, -1, 8'h30, 1'b0},
    '{24'h00_8000, 24'h00_9300, -1, 8'h60, 1'b0},
    '{24'h00_8000, 24'h00_9400, -1, 8'hFA, 1'b0},
    '{24'h00_8000, 24'h00_FEF7, -1, 8'h40, 1'b0},
    '{24'h00_FEFF, 24'h00_9000, -1, 8'h40, 1'b0},
    '{24'h00_7FFF, 24'h00_9000, -1, 8'h40, 1'b1},
    '{24'h01_8000, 24'h00_9000, -1, 8'h40, 1'b1},
    '{24'h00_8001, 24'h00_9000, -1, 8'h40, 1'b1},
    '{24'h00_8000, 24'h00_FEF8, -1, 8'h40, 1'b1},
    '{24'h00_8000, 24'h00_9000, 5, 8'h40, 1'b1},
    '{24'h00_8000, 24'h00_A000, -1, 8'h40, 1'b1}};
  logic [7:0] flash_rd_data;
  assign flash_rd_data = mem[flash_rd.addr];
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    go_seen <= reset_n & (go_seen | cmd_go);
    hex_seen <= reset_n & (hex_seen | hex_start);
    dbg_seen <= reset_n & (dbg_seen | debug_go);
  end
  spp_prog_ctrl u_ctrl (.clk(clk), .link_in(link_in), .cmd_in(cmd_in));
  spp_password_check uut (.clk(clk), .reset_n(reset_n),
    .parallel_mode_pin(par_pin), .link_in(link_in), .cmd_in(cmd_in),
    .chip_erase_done(erase_done), .debug_start_req(dbg_req),
    .flash_rd_data(flash_rd_data), .flash_rd(flash_rd), .cmd_go(cmd_go),
    .auth_ok(auth_ok), .lockup(lockup), .blank_part(blank_part),
    .hex_start(hex_start), .debug_go(debug_go));
////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic got, input logic exp, input string s);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic restart();
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (70) @(posedge clk); // Blank scan finishes first
  endtask
  task automatic debug_pulse();
    @(posedge clk);
    dbg_req <= 1'b1;
    @(posedge clk);
    dbg_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic auth(input logic [23:0] lp, input logic [23:0] cp,
    input int bad, input logic [7:0] c, input logic blank);
    logic [15:0] a;
    int n;
    u_ctrl.start(c);
    u_ctrl.ptr(lp);
    u_ctrl.ptr(cp);
    n = blank ? 0 : int'(mem[lp[15:0]]);
    for (int i = 0; i < n; i++) begin
      a = cp[15:0] + i[15:0];
      u_ctrl.send(mem[a] ^ ((i == bad) ? 8'h01 : 8'h00));
    end
    repeat (4) @(posedge clk);
  endtask
////////////////////////////////////////////////////////////////////////////
  initial begin
    #500_000;
    fails++;
    tally_and_finish();
  end
  initial begin
    logic wr;
    // Byte pattern with no repeats, so only planted faults lock
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;
    mem[16'h8000] = 8'h08;
    mem[16'h8001] = 8'h06;
    mem[16'hFEFF] = 8'h08;
    for (int i = 2; i < 5; i++) mem[16'hA000 + i] = 8'h77;
    foreach (rows[k]) begin
      restart();
      auth(rows[k].lp, rows[k].cp, rows[k].bad, rows[k].code, 1'b0);
      u_ctrl.send(8'h3A);
      repeat (4) @(posedge clk);
      wr = rows[k].code inside {8'h30, 8'h60};
      check(lockup, rows[k].lock, "lock state");
      check(go_seen, !rows[k].lock, "grant");
      check(hex_seen, wr && !rows[k].lock, "hex start");
      check(auth_ok, !rows[k].lock, "auth level");
    end
    par_pin <= 1'b1;
    restart();
    u_ctrl.start(8'h40);
    debug_pulse();
    check(go_seen, 1'b1, "parallel grant");
    check(dbg_seen, 1'b1, "parallel debug");
    par_pin <= 1'b0;
    restart();
    check(blank_part, 1'b0, "non-blank");
    u_ctrl.start(8'hC0);
    debug_pulse();
    check(go_seen, 1'b0, "unauth grant");
    check(dbg_seen, 1'b0, "unauth debug");
    auth(24'h00_8000, 24'h00_9000, -1, 8'h40, 1'b0);
    debug_pulse();
    check(dbg_seen, 1'b1, "auth debug");
    // Whole-chip erase: image all 0xFF
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    @(posedge clk);
    erase_done <= 1'b1;
    @(posedge clk);
    erase_done <= 1'b0;
    repeat (70) @(posedge clk);
    check(auth_ok, 1'b0, "auth after erase");
    check(blank_part, 1'b1, "blank after erase");
    restart();
    check(blank_part, 1'b1, "blank");
    auth(24'h00_8000, 24'h00_9000, -1, 8'h30, 1'b1);
    u_ctrl.send(8'h55);
    check(hex_seen, 1'b0, "junk before mark");
    u_ctrl.send(8'h3A);
    check(hex_seen, 1'b1, "blank hex start");
    restart();
    auth(24'h00_8000, 24'h00_9000, -1, 8'hF0, 1'b1);
    check(go_seen, 1'b1, "blank erase");
    restart();
    auth(24'h00_FF00, 24'h00_9000, -1, 8'h40, 1'b1);
    check(lockup, 1'b1, "blank range");
    tally_and_finish();
  end
endmodule
